// ---- src/nesp_status_regs.sv ----
/*
 Status and result registers of a NAND flash error-correction unit:
 per-sector error flags, the four-error code summary, parity results
 with the corrupted byte and bit address, and codeword/syndrome words.
 Assumes the correction engines run on clk and deliver one-cycle strobes.
*/
// Summary of operation
// - A sector's single-error flag is 1 after a read with one bad bit.
// - In whole-page mode only sector 0 flags are used; PR0/PR1 locate it.
// - In 256-byte mode sector flags 0..15 are used, in 512-byte mode 0..7; type 3 is ignored.
// - The four-error code corrects one 512-byte sub page per run.
// - More than four errors set the uncorrectable flag at status bit 3.
// - A new read/write command or software reset clears that flag.
// - With the flag clear, a 3-bit field gives zero to four errors.
// - In 256-byte mode a parity word holds 11 parity bits, bit 11 zero.
// - In 512-byte mode a parity word holds 12 parity bits, sectors 0..7.
// - A single-error read reports the corrupted byte address.
// - A single-error read reports the corrupted bit offset.
// - Eight 10-bit redundancy words are cut into ten bytes.
// - After a page write each byte sits in bits 7..0 of a codeword reg.
// - A sector's multi-error flag is 1 when more than one error is seen.
// - After a read the same registers hold ten syndrome words per sub page.
`timescale 1ns/1ns
module nesp_status_regs
   import nesp_pkg::*;
#(
   parameter int NUM_SECT = NUM_PR,
   parameter int NUM_CWR  = NUM_CW
)(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // Register port
   input  wire logic [8:0]   regAddr,
   input  wire logic [31:0]  regWdata,
   input  wire logic         regWr,
   input  wire logic         regRd,
   output logic      [31:0]  regRdata,
   // Control
   input  wire logic         swReset,
   input  wire logic         cmdDetect,
   input  wire logic [2:0]   correctionType,
   // Hamming engine result
   input  wire logic         hamValid,
   input  wire logic [3:0]   hamSector,
   input  wire logic         hamSingle,
   input  wire logic         hamMulti,
   input  wire logic [15:0]  hamParity,
   input  wire logic [11:0]  hamWordAddr,
   input  wire logic [2:0]   hamBitOff,
   // Reed-Solomon engine result
   input  wire logic         rsDone,
   input  wire logic [3:0]   rsErrors,
   input  wire logic         rsWordsValid,
   input  wire logic [2:0]   rsSubPage,
   input  wire logic [79:0]  rsRedundancy,
   input  wire logic         synValid,
   input  wire logic [6:0]   synIndex,
   input  wire logic [7:0]   synWord,
   // Status view
   output logic      [15:0]  sectorSingleErrorFlag,
   output logic      [15:0]  sectorMultiErrorFlag,
   output logic              rsUncorrectableFlag,
   output logic      [2:0]   rsErrorCount
);

   // Mode decode.
   logic        isRs;
   logic        isPage;
   logic        is256;
   logic        is512;
   logic        hamOk;
   logic [3:0]  hamSect;

   assign isRs   = correctionType[CT_RS_BIT];
   assign isPage = (correctionType == CT_PAGE);
   assign is256  = (correctionType == CT_S256);
   assign is512  = (correctionType == CT_S512);
   // Reserved Hamming types drop their results rather than guess a layout.
   assign hamOk  = hamValid & (isPage | is256 | is512);
   assign hamSect = isPage ? 4'h0 : hamSector;

   // Parity word formatting.
   logic [31:0] fmtMain;
   logic [31:0] fmtAux;

   nesp_parity_fmt u_fmt (
      .corrType (correctionType),
      .parity   (hamParity),
      .wordAddr (hamWordAddr),
      .bitOff   (hamBitOff),
      .mainWord (fmtMain),
      .auxWord  (fmtAux)
   );

   // Per-sector flags and parity results.
   logic [NUM_SECT-1:0] singleQ;
   logic [NUM_SECT-1:0] multiQ;
   logic [31:0]         prQ [NUM_SECT];

   genvar i;
   generate
      for (i = 0; i < NUM_SECT; i++)
      begin : g_sect
         logic        flagHit;
         logic        prHit;
         logic        auxSel;
         logic [31:0] prD;

         assign flagHit = hamOk & (hamSect == 4'(i));
         // Whole-page mode also fills the second word with the parity.
         assign auxSel  = isPage & (i == 1);
         assign prHit   = flagHit | (hamOk & auxSel);
         assign prD     = auxSel ? fmtAux : fmtMain;

         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               singleQ[i] <= 1'b0;
               multiQ[i]  <= 1'b0;
            end
            else if (swReset)
            begin
               singleQ[i] <= 1'b0;
               multiQ[i]  <= 1'b0;
            end
            else if (flagHit)
            begin
               singleQ[i] <= hamSingle & ~hamMulti;
               multiQ[i]  <= hamMulti;
            end
         end

         // Address and bit fields are stored as delivered; with several
         // errors the engine's values carry no meaning.
         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
               prQ[i] <= REG_RESET;
            else if (swReset)
               prQ[i] <= REG_RESET;
            else if (prHit)
               prQ[i] <= prD;
         end
      end
   endgenerate

   // Four-error code summary.
   logic       tooMany;
   logic       rsUncorrQ;
   logic [2:0] rsCountQ;

   assign tooMany = rsErrors > RS_MAX_ERR;

   // A result in the same cycle as a new command wins over the clear.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rsUncorrQ <= 1'b0;
      else if (swReset)
         rsUncorrQ <= 1'b0;
      else if (rsDone & isRs)
         rsUncorrQ <= tooMany;
      else if (cmdDetect)
         rsUncorrQ <= 1'b0;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rsCountQ <= 3'h0;
      else if (swReset)
         rsCountQ <= 3'h0;
      else if (rsDone & isRs)
         rsCountQ <= tooMany ? 3'h0 : rsErrors[2:0];
   end

   // Codeword and syndrome words.
   logic [7:0] spareBytes [CW_PER_SUB];
   logic [7:0] cwQ [NUM_CWR];

   nesp_cw_pack u_pack (
      .redundancy (rsRedundancy),
      .cwBytes    (spareBytes)
   );

   genvar j;
   generate
      for (j = 0; j < NUM_CWR; j++)
      begin : g_cw
         logic wrHit;
         logic synHit;

         assign wrHit  = isRs & rsWordsValid
                         & (rsSubPage == 3'(j / CW_PER_SUB));
         assign synHit = isRs & synValid & (synIndex == 7'(j));

         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
               cwQ[j] <= 8'h00;
            else if (swReset)
               cwQ[j] <= 8'h00;
            else if (wrHit)
               cwQ[j] <= spareBytes[j % CW_PER_SUB];
            else if (synHit)
               cwQ[j] <= synWord;
         end
      end
   endgenerate

   // Read decode.
   logic        hitSr1;
   logic        hitSr2;
   logic        hitPr;
   logic        hitCw;
   logic [8:0]  prOff;
   logic [8:0]  cwOff;
   logic [3:0]  prIdx;
   logic [6:0]  cwIdx;
   logic        prShown;
   logic [31:0] sr1Word;
   logic [31:0] sr2Ham;
   logic [31:0] sr2Rs;
   logic [31:0] readMux;

   assign prOff  = regAddr - OFF_PR2;
   assign cwOff  = regAddr - OFF_CW0;
   assign hitSr1 = (regAddr == OFF_SR1);
   assign hitSr2 = (regAddr == OFF_SR2);
   assign hitCw  = (regAddr[1:0] == 2'h0)
                   & (regAddr >= OFF_CW0) & (regAddr <= OFF_CW79);
   assign hitPr  = (regAddr == OFF_PR0) | (regAddr == OFF_PR1)
                   | ((regAddr[1:0] == 2'h0)
                      & (regAddr >= OFF_PR2) & (regAddr <= OFF_PR15));
   assign prIdx  = (regAddr == OFF_PR0) ? 4'h0 :
                   (regAddr == OFF_PR1) ? 4'h1 : 4'(prOff[8:2] + 7'h02);
   assign cwIdx  = cwOff[8:2];

   // Registers beyond the sectors of the active mode read as zero.
   assign prShown = is256
                  | (is512 & (prIdx <= 4'(S512_LAST)))
                  | (isPage & (prIdx <= 4'h1));

   generate
      for (i = 0; i < SR_HI_BASE; i++)
      begin : g_sr
         assign sr1Word[i*SR_NIB_W +: SR_NIB_W] =
            {1'b0, multiQ[i], singleQ[i], 1'b0};
         assign sr2Ham[i*SR_NIB_W +: SR_NIB_W] =
            {1'b0, multiQ[i+SR_HI_BASE], singleQ[i+SR_HI_BASE], 1'b0};
      end
   endgenerate

   assign sr2Rs = {28'h000_0000, rsUncorrQ, rsCountQ};

   assign readMux = hitSr1 ? (isRs ? REG_RESET : sr1Word) :
                    hitSr2 ? (isRs ? sr2Rs : sr2Ham) :
                    (hitPr & prShown & ~isRs) ? prQ[prIdx] :
                    hitCw ? {24'h00_0000, cwQ[cwIdx]} : REG_RESET;

   // Writes reach no storage; all registers here are read-only.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         regRdata <= REG_RESET;
      else if (regRd)
         regRdata <= readMux;
      else
         regRdata <= REG_RESET;
   end

   // Status view.
   assign sectorSingleErrorFlag = singleQ;
   assign sectorMultiErrorFlag  = multiQ;
   assign rsUncorrectableFlag   = rsUncorrQ;
   assign rsErrorCount          = rsCountQ;

endmodule : nesp_status_regs

// ---- src/nesp_pkg.sv ----
/*
 Constants shared by the NAND error-correction status and result block:
 register offsets, field positions, reset values and code sizes.
 Assumes byte addressing with one aligned 32-bit word per register.
*/
package nesp_pkg;

   // Register byte offsets.
   localparam logic [8:0]  OFF_SR1     = 9'h008;
   localparam logic [8:0]  OFF_PR0     = 9'h00C;
   localparam logic [8:0]  OFF_PR1     = 9'h010;
   localparam logic [8:0]  OFF_SR2     = 9'h014;
   localparam logic [8:0]  OFF_PR2     = 9'h018;
   localparam logic [8:0]  OFF_PR15    = 9'h04C;
   localparam logic [8:0]  OFF_CW0     = 9'h050;
   localparam logic [8:0]  OFF_CW79    = 9'h18C;

   // Reset value of every result and status register.
   localparam logic [31:0] REG_RESET   = 32'h0000_0000;

   // Correction type encodings; bit 2 set selects the four-error code.
   localparam logic [2:0]  CT_PAGE     = 3'h0;
   localparam logic [2:0]  CT_S256     = 3'h1;
   localparam logic [2:0]  CT_S512     = 3'h2;
   localparam int          CT_RS_BIT   = 2;

   // Register counts and code sizes.
   localparam int          NUM_PR      = 16;
   localparam int          NUM_CW      = 80;
   localparam int          CW_PER_SUB  = 10;
   localparam int          RED_WORDS   = 8;
   localparam int          RED_W       = 10;
   localparam int          BYTE_W      = 8;
   localparam int          S512_LAST   = 7;
   localparam logic [3:0]  RS_MAX_ERR  = 4'h4;

   // Status field positions: one nibble per sector, and the code summary.
   localparam int          SR_NIB_W    = 4;
   localparam int          SR_SGL_POS  = 1;
   localparam int          SR_MUL_POS  = 2;
   localparam int          SR_HI_BASE  = 8;
   localparam int          RS_MUL_POS  = 3;
   localparam int          RS_CNT_W    = 3;

   // Parity result field positions.
   localparam int          PR_PAR_LSB  = 12;
   localparam int          PR_ADR_LSB  = 3;
   localparam int          PR_BIT_W    = 3;

endpackage : nesp_pkg

// ---- src/nesp_parity_fmt.sv ----
/*
 Arranges one Hamming result (parity, corrupted byte address, bit offset)
 into the parity result register layout of the selected correction type.
 Assumes the inputs are steady while the caller samples the outputs.
*/
`timescale 1ns/1ns
module nesp_parity_fmt
   import nesp_pkg::*;
(
   // Selected correction type
   input  wire logic [2:0]  corrType,
   // Raw result
   input  wire logic [15:0] parity,
   input  wire logic [11:0] wordAddr,
   input  wire logic [2:0]  bitOff,
   // Formatted words
   output logic      [31:0] mainWord,
   output logic      [31:0] auxWord
);

   logic [31:0] pageWord;
   logic [31:0] s256Word;
   logic [31:0] s512Word;

   // Whole page: the address word, and parity alone in a second word.
   assign pageWord = {17'h0_0000, wordAddr, bitOff};
   // 256-byte sector: bit 11 always reads zero.
   assign s256Word = {9'h000, parity[10:0], 1'b0, wordAddr[7:0], bitOff};
   assign s512Word = {8'h00, parity[11:0], wordAddr[8:0], bitOff};

   assign mainWord = (corrType == CT_S256) ? s256Word :
                     (corrType == CT_S512) ? s512Word : pageWord;
   assign auxWord  = {16'h0000, parity};

endmodule : nesp_parity_fmt

// ---- src/nesp_cw_pack.sv ----
/*
 Cuts the concatenated redundancy words of one 512-byte sub page into
 bytes for the spare area; word 0 sits in the least significant bits.
 Assumes the caller captures the bytes on its own strobe.
*/
`timescale 1ns/1ns
module nesp_cw_pack
   import nesp_pkg::*;
#(
   parameter int WORDS = RED_WORDS,
   parameter int WW    = RED_W,
   parameter int BYTES = CW_PER_SUB
)(
   // Concatenated redundancy
   input  wire logic [WORDS*WW-1:0] redundancy,
   // Spare-area bytes
   output logic      [7:0]          cwBytes [BYTES]
);

   genvar k;
   generate
      for (k = 0; k < BYTES; k++)
      begin : g_byte
         assign cwBytes[k] = redundancy[k*BYTE_W +: BYTE_W];
      end
   endgenerate

endmodule : nesp_cw_pack

// ---- sim/nesp_properties.sv ----
/*
 Concurrent checks on the ports of the status and result register block.
 Assumes one clock domain and the asynchronous active-low reset nrst.
*/
`timescale 1ns/1ns
module nesp_props (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Register port
   input  wire logic        regRd,
   input  wire logic [31:0] regRdata,
   // Control
   input  wire logic        swReset,
   input  wire logic        cmdDetect,
   input  wire logic [2:0]  correctionType,
   // Engine results
   input  wire logic        hamValid,
   input  wire logic [3:0]  hamSector,
   input  wire logic        hamSingle,
   input  wire logic        hamMulti,
   input  wire logic        rsDone,
   input  wire logic [3:0]  rsErrors,
   // Status view
   input  wire logic [15:0] sectorSingleErrorFlag,
   input  wire logic [15:0] sectorMultiErrorFlag,
   input  wire logic        rsUncorrectableFlag,
   input  wire logic [2:0]  rsErrorCount
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // Page mode folds every result onto sector 0.
   wire logic [3:0] sectIdx  = (correctionType == 3'h0) ? 4'h0 : hamSector;
   wire logic       hamTaken = hamValid && correctionType < 3'h3 && !swReset;
   wire logic       rsTaken  = rsDone && correctionType[2] && !swReset;

   a_single_flag: assert property (
      hamTaken |=> sectorSingleErrorFlag[$past(sectIdx)]
      == $past(hamSingle && !hamMulti))
      else $error("single flag wrong");
   a_multi_flag: assert property (
      hamTaken |=> sectorMultiErrorFlag[$past(sectIdx)] == $past(hamMulti))
      else $error("multi flag wrong");
   a_reserved_ignored: assert property (
      (correctionType == 3'h3 || correctionType[2]) && !swReset
      |=> $stable(sectorSingleErrorFlag) && $stable(sectorMultiErrorFlag))
      else $error("flags moved outside hamming mode");
   a_rs_uncorr: assert property (
      rsTaken && rsErrors > 4'h4
      |=> rsUncorrectableFlag && rsErrorCount == 3'h0)
      else $error("uncorrectable flag missing");
   a_rs_count: assert property (
      rsTaken && rsErrors <= 4'h4
      |=> !rsUncorrectableFlag && {1'b0, rsErrorCount} == $past(rsErrors))
      else $error("error count wrong");
   a_count_hold: assert property (
      (!rsDone || !correctionType[2]) && !swReset |=> $stable(rsErrorCount))
      else $error("error count moved");
   a_cmd_clear: assert property (
      cmdDetect && !rsTaken |=> !rsUncorrectableFlag)
      else $error("command did not clear flag");
   a_sw_clear: assert property (
      swReset |=> !rsUncorrectableFlag && rsErrorCount == 3'h0
      && sectorSingleErrorFlag == 16'h0 && sectorMultiErrorFlag == 16'h0)
      else $error("software reset did not clear");
   a_rd_idle: assert property (
      regRdata != 32'h0 |-> $past(regRd))
      else $error("read data outside its cycle");

   cover property (hamTaken && hamMulti);
   cover property (rsTaken && rsErrors > 4'h4);
   cover property (cmdDetect && rsUncorrectableFlag);
endmodule : nesp_props

bind nesp_status_regs nesp_props chk (
   .clk, .nrst, .regRd, .regRdata, .swReset, .cmdDetect, .correctionType,
   .hamValid, .hamSector, .hamSingle, .hamMulti, .rsDone, .rsErrors,
   .sectorSingleErrorFlag, .sectorMultiErrorFlag, .rsUncorrectableFlag,
   .rsErrorCount
);

// ---- sim/nesp_flash_model.sv ----
/*
 Behavioural page data stream engines feeding the status block.
 Assumes the bench calls one task at a time; fields turn to their inverse
 once a strobe drops, so stale values are never mistaken for valid ones.
*/
`timescale 1ns/1ns
module nesp_flash_model (
   // Clock
   input  wire logic        clk,
   // Hamming result
   output logic             hamValid,
   output logic      [3:0]  hamSector,
   output logic             hamSingle,
   output logic             hamMulti,
   output logic      [15:0] hamParity,
   output logic      [11:0] hamWordAddr,
   output logic      [2:0]  hamBitOff,
   // Reed-Solomon result
   output logic             rsDone,
   output logic      [3:0]  rsErrors,
   output logic             rsWordsValid,
   output logic      [2:0]  rsSubPage,
   output logic      [79:0] rsRedundancy,
   output logic             synValid,
   output logic      [6:0]  synIndex,
   output logic      [7:0]  synWord
);
   initial
   begin
      {hamValid, rsDone, rsWordsValid, synValid} = 4'h0;
      {hamSector, hamSingle, hamMulti, hamParity, hamWordAddr} = '0;
      {hamBitOff, rsErrors, rsSubPage, rsRedundancy} = '0;
      {synIndex, synWord} = '0;
   end

   task ham(input logic [36:0] f);
      @(posedge clk);
      hamValid <= 1'b1;
      {hamSector, hamSingle, hamMulti, hamParity, hamWordAddr, hamBitOff} <= f;
      @(posedge clk);
      hamValid <= 1'b0;
      {hamSector, hamSingle, hamMulti, hamParity, hamWordAddr, hamBitOff} <= ~f;
   endtask : ham

   // One correction run covers a single 512-byte sub page.
   task rs(input logic [3:0] e);
      @(posedge clk);
      rsDone   <= 1'b1;
      rsErrors <= e;
      @(posedge clk);
      rsDone   <= 1'b0;
      rsErrors <= ~e;
   endtask : rs

   task cw(input logic [82:0] f);
      @(posedge clk);
      rsWordsValid              <= 1'b1;
      {rsSubPage, rsRedundancy} <= f;
      @(posedge clk);
      rsWordsValid              <= 1'b0;
      {rsSubPage, rsRedundancy} <= ~f;
   endtask : cw

   task syn(input logic [14:0] f);
      @(posedge clk);
      synValid            <= 1'b1;
      {synIndex, synWord} <= f;
      @(posedge clk);
      synValid            <= 1'b0;
      {synIndex, synWord} <= ~f;
   endtask : syn
endmodule : nesp_flash_model

// ---- sim/tb_top.sv ----
/*
 Self-checking bench for the status and result register block.
 Assumes the flash model and the bound property checker are compiled.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) \
   begin \
      numChecks++; \
      if ((g) !== (e)) \
      begin \
         badCount++; \
         $display("MISMATCH %s expected %h seen %h", nm, e, g); \
      end \
   end
module tb_top
   import nesp_pkg::*;
;
   typedef struct {
      logic [2:0] ty; logic [36:0] f; logic [8:0] ra; logic [31:0] ex;
   } nesp_row_t;

   logic        clk, nrst, regWr, regRd, swReset, cmdDetect;
   logic        hamValid, hamSingle, hamMulti, rsDone, rsWordsValid, synValid;
   logic        rsUncorrectableFlag;
   logic [2:0]  correctionType, hamBitOff, rsSubPage, rsErrorCount;
   logic [3:0]  hamSector, rsErrors, idx;
   logic [6:0]  synIndex;
   logic [7:0]  synWord;
   logic [8:0]  regAddr;
   logic [11:0] hamWordAddr;
   logic [15:0] hamParity, sectorSingleErrorFlag, sectorMultiErrorFlag;
   logic [15:0] mask, sglExp, mulExp;
   logic [31:0] regWdata, regRdata, got;
   logic [79:0] rsRedundancy;
   logic [79:0] red = 80'h0123_4567_89AB_CDEF_FEDC;
   int          badCount = 0;
   int          numChecks = 0;
   nesp_row_t   rows [8];
   logic [8:0]  rstAddr [6] = '{9'h008, 9'h00C, 9'h014, 9'h01C, 9'h050, 9'h1C0};

   nesp_status_regs DUT (.clk, .nrst, .regAddr, .regWdata, .regWr, .regRd,
      .regRdata, .swReset, .cmdDetect, .correctionType, .hamValid, .hamSector,
      .hamSingle, .hamMulti, .hamParity, .hamWordAddr, .hamBitOff, .rsDone,
      .rsErrors, .rsWordsValid, .rsSubPage, .rsRedundancy, .synValid,
      .synIndex, .synWord, .sectorSingleErrorFlag, .sectorMultiErrorFlag,
      .rsUncorrectableFlag, .rsErrorCount);
   nesp_flash_model PARTNER (.clk, .hamValid, .hamSector, .hamSingle,
      .hamMulti, .hamParity, .hamWordAddr, .hamBitOff, .rsDone, .rsErrors,
      .rsWordsValid, .rsSubPage, .rsRedundancy, .synValid, .synIndex,
      .synWord);

   always #5 clk = ~clk;

   task endSim();
      if (badCount == 0 && numChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : endSim

   task rdChk(input logic [8:0] a, input logic [31:0] e);
      @(posedge clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd   <= 1'b0;
      regAddr <= ~a;
      #1 got = regRdata;
      `CHK("regRdata", e, got)
   endtask : rdChk

   task wr(input logic [8:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWr    <= 1'b0;
   endtask : wr

   // A high argument pulses the command detect, a low one software reset.
   task pulse(input logic c);
      @(posedge clk);
      if (c)
         cmdDetect <= 1'b1;
      else
         swReset <= 1'b1;
      @(posedge clk);
      cmdDetect <= 1'b0;
      swReset   <= 1'b0;
      #1;
   endtask : pulse

   initial
   begin
      #50000;
      badCount++;
      endSim();
   end

   initial
   begin
      rows = '{'{3'h0, {6'h2, 16'hA5C3, 12'h9E1, 3'h5}, 9'h00C, 32'h4F0D},
               '{3'h0, {6'h2, 16'hA5C3, 12'h9E1, 3'h5}, 9'h010, 32'hA5C3},
               '{3'h1, {6'hE, 16'h05A3, 12'h0C7, 3'h2}, 9'h01C, 32'h5A363A},
               '{3'h2, {6'h1E, 16'h0FED, 12'h1F0, 3'h7}, 9'h02C, 32'hFEDF87},
               '{3'h1, {6'h15, 16'h0000, 12'h000, 3'h0}, 9'h008, 32'h400000},
               '{3'h1, {6'h2A, 16'h0000, 12'h000, 3'h0}, 9'h014, 32'h200},
               '{3'h3, {6'hA, 16'h0123, 12'h045, 3'h1}, 9'h008, 32'h0},
               '{3'h4, {6'hB, 16'h0123, 12'h045, 3'h1}, 9'h008, 32'h0}};
      clk = 1'b0;
      nrst = 1'b0;
      {regAddr, regWdata, regWr, regRd} = '0;
      {swReset, cmdDetect} = 2'h0;
      correctionType = 3'h0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      wr(9'h01C, 32'hFFFF_FFFF);
      foreach (rstAddr[i])
         rdChk(rstAddr[i], 32'h0);
      foreach (rows[i])
      begin
         @(posedge clk);
         correctionType <= rows[i].ty;
         pulse(1'b0);
         PARTNER.ham(rows[i].f);
         rdChk(rows[i].ra, rows[i].ex);
         idx    = (rows[i].ty == CT_PAGE) ? 4'h0 : rows[i].f[36:33];
         mask   = (rows[i].ty < 3'h3) ? 16'h1 << idx : 16'h0;
         sglExp = (rows[i].f[32] && !rows[i].f[31]) ? mask : 16'h0;
         mulExp = rows[i].f[31] ? mask : 16'h0;
         `CHK("single", sglExp, sectorSingleErrorFlag)
         `CHK("multi", mulExp, sectorMultiErrorFlag)
      end
      PARTNER.cw({3'h1, red});
      for (int k = 0; k < 10; k++)
         rdChk(OFF_CW0 + 9'(4 * (10 + k)), {24'h0, red[8*k +: 8]});
      PARTNER.syn({7'h4F, 8'h5A});
      wr(OFF_CW79, 32'hFFFF_FFFF);
      rdChk(OFF_CW79, 32'h5A);
      for (int e = 0; e < 6; e++)
      begin
         PARTNER.rs(4'(e));
         rdChk(OFF_SR2, (e > 4) ? 32'h8 : 32'(e));
      end
      pulse(1'b1);
      `CHK("uncorrectable", 1'b0, rsUncorrectableFlag)
      PARTNER.rs(4'hF);
      pulse(1'b0);
      `CHK("uncorrectable", 1'b0, rsUncorrectableFlag)
      PARTNER.rs(4'h3);
      correctionType <= 3'h0;
      PARTNER.rs(4'h9);
      #1 `CHK("count", 3'h3, rsErrorCount)
      `CHK("uncorrectable", 1'b0, rsUncorrectableFlag)
      endSim();
   end
endmodule : tb_top
